// >>> bench/blt_feed.sv
`timescale 1ns/1ps

// Stand-in for the peak detector and supply monitor, refreshed once per clock
module blt_feed
	import blt_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [VOLT_W-1:0] set_signal,
	input  wire logic [VOLT_W-1:0] set_battery,
	output logic      [VOLT_W-1:0] signal_level,
	output logic      [VOLT_W-1:0] battery_level
);
	initial begin
		signal_level  = '0;
		battery_level = 10'h258;
	end

	always @(posedge clk) begin
		signal_level  <= set_signal;
		battery_level <= set_battery;
	end
endmodule

// >>> bench/blt_limiter_asserts.sv
`timescale 1ns/1ps

module blt_limiter_asserts
	import blt_pkg::*;
#(
	parameter int US_TICK_CYC = TICK_CYC_DEF
) (
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic [VOLT_W-1:0] signal_level,
	input wire logic [VOLT_W-1:0] battery_level,
	input wire logic [ATN_W-1:0]  attenuation_q,
	input wire logic              limiter_active,
	input wire logic              guard_active
);
	blt_cfg_t          cfg;
	logic [VOLT_W-1:0] up_v;
	logic [VOLT_W-1:0] lo_v;
	logic [VOLT_W-1:0] knee_v;
	logic              dip;

	// Shadow of the fields the checks depend on
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg <= '{LIMITER_ENABLE_RST, GUARD_EN_RST, ATK_INT_RST, HOLD_RST, REL_INT_RST, ATK_STEP_RST,
				REL_STEP_RST, CEIL_RST, UPPER_RST, KNEE_RST, LOWER_RST, SLOPE_RST, GUARD_TH_RST};
		end else if (reg_wr && reg_addr == CTRL_OFS) begin
			cfg.limiter_enable <= reg_wdata[LIMITER_ENABLE_BIT];
			cfg.guard_enable   <= reg_wdata[GUARD_EN_BIT];
		end else if (reg_wr && reg_addr == TIMING_OFS) begin
			cfg.attack_step_db      <= reg_wdata[ATK_STEP_LSB +: 2];
			cfg.attenuation_ceiling <= reg_wdata[CEIL_LSB +: 5];
		end else if (reg_wr && reg_addr == THRESH_OFS) begin
			cfg.upper_threshold <= reg_wdata[UPPER_LSB +: 7];
			cfg.tracking_knee   <= reg_wdata[KNEE_LSB +: 7];
			cfg.lower_threshold <= reg_wdata[LOWER_LSB +: 7];
		end else if (reg_wr && reg_addr == GUARD_OFS) begin
			cfg.brownout_guard_threshold <= reg_wdata[7:0];
		end
	end

	assign up_v   = VOLT_W'(THR_BASE + THR_PER * cfg.upper_threshold);
	assign lo_v   = VOLT_W'(THR_BASE + THR_PER * cfg.lower_threshold);
	assign knee_v = VOLT_W'(THR_BASE + THR_PER * cfg.tracking_knee);
	assign dip    = cfg.guard_enable && battery_level < GUARD_BASE + cfg.brownout_guard_threshold;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_over;
		cfg.limiter_enable && !dip && battery_level >= knee_v && signal_level > up_v;
	endsequence

	sequence s_rise;
		attenuation_q > $past(attenuation_q);
	endsequence

	AST_LIM_GATED: assert property ($rose(limiter_active) |-> $past(cfg.limiter_enable, 2))
		else $error("limiter started while disabled");
	AST_LIM_TRIGGER: assert property (s_over [*3] |-> ##[0:2] limiter_active)
		else $error("limiter did not start on overshoot");
	AST_RISE_CAUSE: assert property (s_rise |-> limiter_active || guard_active)
		else $error("attenuation rose with both features idle");
	AST_CEILING: assert property (
		s_rise |-> attenuation_q <= ATN_BASE + ATN_PER * $past(cfg.attenuation_ceiling, 2))
		else $error("attenuation passed ceiling");
	AST_STEP: assert property (
		s_rise |-> attenuation_q - $past(attenuation_q) <= 1 << $past(cfg.attack_step_db, 2))
		else $error("attack step too large");
	AST_GUARD_REACT: assert property (dip [*3] |-> ##[0:250] guard_active)
		else $error("guard late");
	AST_IDLE_ZERO: assert property (
		(!limiter_active && !guard_active) [*2] |-> attenuation_q == 0)
		else $error("idle with attenuation left");
	AST_THR_BOUNDS: assert property (
		reg_rd && reg_addr == STATUS_OFS && $past(rstn) && $stable(cfg)
		&& cfg.lower_threshold <= cfg.upper_threshold
		|=> reg_rdata[ST_THR_LSB +: VOLT_W] >= $past(lo_v)
		&& reg_rdata[ST_THR_LSB +: VOLT_W] <= $past(up_v))
		else $error("threshold outside bounds");
endmodule

bind blt_limiter blt_limiter_asserts #(.US_TICK_CYC(US_TICK_CYC)) u_asserts (.clk(clk),
	.rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .signal_level(signal_level), .battery_level(battery_level),
	.attenuation_q(attenuation_q), .limiter_active(limiter_active), .guard_active(guard_active));

// >>> bench/tb_top.sv
`timescale 1ns/1ps

module tb_top
	import blt_pkg::*;
;
	logic              clk;
	logic              rstn;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	logic [VOLT_W-1:0] set_signal;
	logic [VOLT_W-1:0] set_battery;
	logic [VOLT_W-1:0] signal_level;
	logic [VOLT_W-1:0] battery_level;
	logic [ATN_W-1:0]  attenuation_q;
	logic              limiter_active;
	logic              guard_active;
	int                num_errors;
	int                comparisons;

	blt_feed u_feed (.clk(clk), .set_signal(set_signal), .set_battery(set_battery),
		.signal_level(signal_level), .battery_level(battery_level));

	// One tick per clock keeps hold and release spans short
	blt_limiter #(.US_TICK_CYC(1)) u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.signal_level(signal_level), .battery_level(battery_level),
		.attenuation_q(attenuation_q), .limiter_active(limiter_active),
		.guard_active(guard_active));

	task automatic finish_test();
		if (num_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	// Bounded wait for a total attenuation, then compare it
	task automatic wait_atn(input logic [ATN_W-1:0] exp, input int n);
		int i;
		i = 0;
		while (attenuation_q !== exp && i < n) begin
			@(posedge clk);
			#1;
			i++;
		end
		check(32'(attenuation_q), 32'(exp));
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (80000) @(posedge clk);
		num_errors++;
		finish_test();
	end

	initial begin
		num_errors  = 0;
		comparisons = 0;
		rstn        = 1'b0;
		reg_addr    = '0;
		reg_wdata   = '0;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		set_signal  = '0;
		set_battery = 10'h258;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rd(CTRL_OFS, 32'h0000_0002);
		rd(TIMING_OFS, 32'h0010_5662);
		rd(THRESH_OFS, 32'h001e_586e);
		rd(GUARD_OFS, 32'h0000_0014);
		rd(STATUS_OFS, 32'h0208_0000);
		wr(STATUS_OFS, '1);
		rd(STATUS_OFS, 32'h0208_0000);
		rd(8'h20, '0);
		// Battery 10 V, 0.8 V under the knee
		@(posedge clk) set_battery <= 10'h190;
		for (int s = 0; s < 4; s++) begin
			wr(THRESH_OFS, {6'h0, 2'(s), 24'h1e_586e});
			idle(3);
			rd(STATUS_OFS, {6'h0, 10'(520 - 16 * SLOPE_X2[s]), 16'h0});
		end
		@(posedge clk) set_battery <= 10'h0fa;
		idle(4);
		rd(STATUS_OFS, 32'h00c8_0000);
		wr(THRESH_OFS, 32'h001e_586e);
		idle(3);
		rd(STATUS_OFS, 32'h0152_0000);
		@(posedge clk) begin
			set_battery <= 10'h258;
			set_signal  <= 10'h258;
		end
		wr(TIMING_OFS, 32'h0001_d010);
		idle(20);
		check(32'({limiter_active, attenuation_q}), 32'h0);
		wr(CTRL_OFS, 32'h3);
		wait_atn(7'h02, 10);
		wait_atn(7'h06, 30);
		idle(20);
		check(32'({limiter_active, attenuation_q}), 32'h86);
		@(posedge clk) set_signal <= '0;
		wr(TIMING_OFS, 32'h0003_d010);
		@(posedge clk) set_battery <= 10'h0be;
		wait_atn(7'h08, 250);
		check(32'(guard_active), 32'h1);
		wait_atn(7'h0a, 100);
		idle(30);
		check(32'(attenuation_q), 32'h0a);
		@(posedge clk) set_battery <= 10'h258;
		idle(100);
		check(32'(attenuation_q), 32'h0a);
		// Limiter share clears first, having entered hold before the battery dip
		wait_atn(7'h04, 45000);
		wait_atn(7'h00, 200);
		idle(2);
		check(32'({guard_active, limiter_active}), 32'h0);
		finish_test();
	end
endmodule

// >>> rtl/blt_limiter.sv
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps

module blt_limiter
	import blt_pkg::*;
#(
	parameter int US_TICK_CYC = TICK_CYC_DEF
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic [VOLT_W-1:0] signal_level,
	input  wire logic [VOLT_W-1:0] battery_level,
	output logic      [ATN_W-1:0]  attenuation_q,
	output logic                   limiter_active,
	output logic                   guard_active
);

	blt_cfg_t         cfg;
	logic [15:0]      tick_cnt;
	logic             tick;
	logic [VOLT_W-1:0] thr;
	logic [VOLT_W-1:0] next_thr;
	logic [VOLT_W-1:0] guard_thr;
	logic [ATN_W-1:0] lim_atn;
	logic [ATN_W-1:0] guard_atn;
	logic [ATN_W-1:0] ceiling;
	logic [ATN_W-1:0] headroom;
	logic [ATN_W-1:0] atk_q;
	logic [ATN_W-1:0] rel_q;
	logic [ATN_W-1:0] atk_amt;
	logic [TIMER_W-1:0] atk_val;
	logic [TIMER_W-1:0] hold_val;
	logic [TIMER_W-1:0] rel_val;
	logic             over;
	logic             below;
	blt_phase_t       lim_ph;
	blt_phase_t       next_lim_ph;
	blt_phase_t       grd_ph;
	blt_phase_t       next_grd_ph;
	logic             lim_load;
	logic             grd_load;
	logic [TIMER_W-1:0] lim_val;
	logic [TIMER_W-1:0] grd_val;
	logic             lim_exp;
	logic             grd_exp;
	logic [ATN_W-1:0] lim_add;
	logic [ATN_W-1:0] lim_sub;
	logic [ATN_W-1:0] grd_add;
	logic [ATN_W-1:0] grd_sub;

	// Register writes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg.limiter_enable           <= LIMITER_ENABLE_RST;
			cfg.guard_enable             <= GUARD_EN_RST;
			cfg.attack_interval          <= ATK_INT_RST;
			cfg.hold_duration            <= HOLD_RST;
			cfg.release_interval         <= REL_INT_RST;
			cfg.attack_step_db           <= ATK_STEP_RST;
			cfg.release_step_db          <= REL_STEP_RST;
			cfg.attenuation_ceiling      <= CEIL_RST;
			cfg.upper_threshold          <= UPPER_RST;
			cfg.tracking_knee            <= KNEE_RST;
			cfg.lower_threshold          <= LOWER_RST;
			cfg.tracking_slope           <= SLOPE_RST;
			cfg.brownout_guard_threshold <= GUARD_TH_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				CTRL_OFS: begin
					cfg.limiter_enable <= reg_wdata[LIMITER_ENABLE_BIT];
					cfg.guard_enable   <= reg_wdata[GUARD_EN_BIT];
				end
				TIMING_OFS: begin
					cfg.attack_interval     <= reg_wdata[ATK_INT_LSB +: 3];
					cfg.hold_duration       <= reg_wdata[HOLD_LSB +: 3];
					cfg.release_interval    <= reg_wdata[REL_INT_LSB +: 3];
					cfg.attack_step_db      <= reg_wdata[ATK_STEP_LSB +: 2];
					cfg.release_step_db     <= reg_wdata[REL_STEP_LSB +: 2];
					cfg.attenuation_ceiling <= reg_wdata[CEIL_LSB +: 5];
				end
				THRESH_OFS: begin
					cfg.upper_threshold <= reg_wdata[UPPER_LSB +: 7];
					cfg.tracking_knee   <= reg_wdata[KNEE_LSB +: 7];
					cfg.lower_threshold <= reg_wdata[LOWER_LSB +: 7];
					cfg.tracking_slope  <= reg_wdata[SLOPE_LSB +: 2];
				end
				GUARD_OFS: begin
					cfg.brownout_guard_threshold <= reg_wdata[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads, data valid the cycle after the strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= '0;
			unique case (reg_addr)
				CTRL_OFS: begin
					reg_rdata[LIMITER_ENABLE_BIT]   <= cfg.limiter_enable;
					reg_rdata[GUARD_EN_BIT] <= cfg.guard_enable;
				end
				TIMING_OFS: begin
					reg_rdata[ATK_INT_LSB +: 3]  <= cfg.attack_interval;
					reg_rdata[HOLD_LSB +: 3]     <= cfg.hold_duration;
					reg_rdata[REL_INT_LSB +: 3]  <= cfg.release_interval;
					reg_rdata[ATK_STEP_LSB +: 2] <= cfg.attack_step_db;
					reg_rdata[REL_STEP_LSB +: 2] <= cfg.release_step_db;
					reg_rdata[CEIL_LSB +: 5]     <= cfg.attenuation_ceiling;
				end
				THRESH_OFS: begin
					reg_rdata[UPPER_LSB +: 7] <= cfg.upper_threshold;
					reg_rdata[KNEE_LSB +: 7]  <= cfg.tracking_knee;
					reg_rdata[LOWER_LSB +: 7] <= cfg.lower_threshold;
					reg_rdata[SLOPE_LSB +: 2] <= cfg.tracking_slope;
				end
				GUARD_OFS: begin
					reg_rdata[7:0] <= cfg.brownout_guard_threshold;
				end
				STATUS_OFS: begin
					reg_rdata[ST_ATN_LSB +: ATN_W]  <= attenuation_q;
					reg_rdata[ST_LIM_BIT]           <= limiter_active;
					reg_rdata[ST_GUARD_BIT]         <= guard_active;
					reg_rdata[ST_THR_LSB +: VOLT_W] <= thr;
				end
				default: begin
				end
			endcase
		end
	end

	// Microsecond tick
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= '0;
		end else if (tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
		end
	end

	assign tick = (tick_cnt == 16'(US_TICK_CYC - 1));

	// Tracked threshold, 25 mV units
	always_comb begin
		logic [15:0] upper;
		logic [15:0] knee;
		logic [15:0] lower;
		logic [15:0] drop;
		logic [15:0] cut;
		logic [15:0] tracked;
		upper = 16'(THR_BASE + THR_PER * int'(cfg.upper_threshold));
		knee  = 16'(THR_BASE + THR_PER * int'(cfg.tracking_knee));
		lower = 16'(THR_BASE + THR_PER * int'(cfg.lower_threshold));
		drop  = (16'(battery_level) < knee) ? knee - 16'(battery_level) : 16'h0000;
		cut   = 16'((int'(drop) * SLOPE_X2[cfg.tracking_slope]) / 2);
		tracked = (cut >= upper) ? 16'h0000 : upper - cut;
		if (lower > upper) begin
			lower = upper;
		end
		if (drop == 16'h0000) begin
			next_thr = VOLT_W'(upper);
		end else if (tracked < lower) begin
			next_thr = VOLT_W'(lower);
		end else begin
			next_thr = VOLT_W'(tracked);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			thr <= VOLT_W'(THR_BASE);
		end else begin
			thr <= next_thr;
		end
	end

	// Decoded settings
	assign guard_thr = VOLT_W'(GUARD_BASE + int'(cfg.brownout_guard_threshold));
	assign ceiling   = ATN_W'(ATN_BASE + ATN_PER * int'(cfg.attenuation_ceiling));
	assign atk_q     = ATN_W'(STEP_Q[cfg.attack_step_db]);
	assign rel_q     = ATN_W'(STEP_Q[cfg.release_step_db]);
	assign atk_val   = TIMER_W'(ATTACK_US[cfg.attack_interval]);
	assign hold_val  = TIMER_W'(HOLD_MS[cfg.hold_duration] * US_PER_MS);
	assign rel_val   = TIMER_W'(RELEASE_MS[cfg.release_interval] * US_PER_MS);

	// Shared budget
	always_comb begin
		logic [ATN_W:0] used;
		used     = {1'b0, lim_atn} + {1'b0, guard_atn};
		headroom = (used >= {1'b0, ceiling}) ? '0 : ATN_W'({1'b0, ceiling} - used);
		atk_amt  = (atk_q < headroom) ? atk_q : headroom;
	end

	assign over  = cfg.limiter_enable && (signal_level > thr);
	assign below = cfg.guard_enable && (battery_level < guard_thr);

	// Guard sequencing
	always_comb begin
		next_grd_ph = grd_ph;
		grd_load    = 1'b0;
		grd_val     = atk_val;
		grd_add     = '0;
		grd_sub     = '0;
		unique case (grd_ph)
			PH_IDLE: begin
				if (below) begin
					next_grd_ph = PH_ATTACK;
					grd_load    = 1'b1;
					grd_add     = atk_amt;
				end
			end
			PH_ATTACK: begin
				if (!below) begin
					next_grd_ph = PH_HOLD;
					grd_load    = 1'b1;
					grd_val     = hold_val;
				end else if (grd_exp) begin
					grd_load = 1'b1;
					grd_add  = atk_amt;
				end
			end
			PH_HOLD: begin
				if (below) begin
					next_grd_ph = PH_ATTACK;
					grd_load    = 1'b1;
					grd_add     = atk_amt;
				end else if (grd_exp) begin
					next_grd_ph = PH_RELEASE;
					grd_load    = 1'b1;
					grd_val     = rel_val;
				end
			end
			PH_RELEASE: begin
				grd_val = rel_val;
				if (below) begin
					next_grd_ph = PH_ATTACK;
					grd_load    = 1'b1;
					grd_val     = atk_val;
					grd_add     = atk_amt;
				end else if (guard_atn == '0) begin
					next_grd_ph = PH_IDLE;
				end else if (grd_exp) begin
					grd_load = 1'b1;
					grd_sub  = (rel_q < guard_atn) ? rel_q : guard_atn;
				end
			end
		endcase
	end

	// Limiter sequencing; only the guard attacks while battery is low
	always_comb begin
		logic [ATN_W-1:0] step;
		step        = below ? '0 : atk_amt;
		next_lim_ph = lim_ph;
		lim_load    = 1'b0;
		lim_val     = atk_val;
		lim_add     = '0;
		lim_sub     = '0;
		unique case (lim_ph)
			PH_IDLE: begin
				if (over) begin
					next_lim_ph = PH_ATTACK;
					lim_load    = 1'b1;
					lim_add     = step;
				end
			end
			PH_ATTACK: begin
				if (!over) begin
					next_lim_ph = PH_HOLD;
					lim_load    = 1'b1;
					lim_val     = hold_val;
				end else if (lim_exp) begin
					lim_load = 1'b1;
					lim_add  = step;
				end
			end
			PH_HOLD: begin
				if (over) begin
					next_lim_ph = PH_ATTACK;
					lim_load    = 1'b1;
					lim_add     = step;
				end else if (lim_exp || !cfg.limiter_enable) begin
					next_lim_ph = PH_RELEASE;
					lim_load    = 1'b1;
					lim_val     = rel_val;
				end
			end
			PH_RELEASE: begin
				lim_val = rel_val;
				if (over) begin
					next_lim_ph = PH_ATTACK;
					lim_load    = 1'b1;
					lim_val     = atk_val;
					lim_add     = step;
				end else if (lim_atn == '0) begin
					next_lim_ph = PH_IDLE;
				end else if (lim_exp) begin
					lim_load = 1'b1;
					lim_sub  = (rel_q < lim_atn) ? rel_q : lim_atn;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			grd_ph    <= PH_IDLE;
			guard_atn <= '0;
		end else begin
			grd_ph    <= next_grd_ph;
			guard_atn <= guard_atn + grd_add - grd_sub;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lim_ph  <= PH_IDLE;
			lim_atn <= '0;
		end else begin
			lim_ph  <= next_lim_ph;
			lim_atn <= lim_atn + lim_add - lim_sub;
		end
	end

	// Registered outputs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			attenuation_q  <= '0;
			limiter_active <= 1'b0;
			guard_active   <= 1'b0;
		end else begin
			attenuation_q  <= lim_atn + guard_atn;
			limiter_active <= (lim_ph != PH_IDLE);
			guard_active   <= (grd_ph != PH_IDLE);
		end
	end

	blt_timer #(
		.WIDTH(TIMER_W)
	) u_lim_timer (
		.clk     (clk),
		.rstn    (rstn),
		.tick    (tick),
		.load    (lim_load),
		.load_val(lim_val),
		.expired (lim_exp)
	);

	blt_timer #(
		.WIDTH(TIMER_W)
	) u_grd_timer (
		.clk     (clk),
		.rstn    (rstn),
		.tick    (tick),
		.load    (grd_load),
		.load_val(grd_val),
		.expired (grd_exp)
	);

endmodule

// >>> rtl/blt_pkg.sv
package blt_pkg;

	// Clock and time base
	localparam int CLK_HZ       = 25_000_000;
	localparam int US_PER_S     = 1_000_000;
	localparam int US_PER_MS    = 1_000;
	localparam int TICK_CYC_DEF = CLK_HZ / US_PER_S;

	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] TIMING_OFS = 8'h04;
	localparam logic [7:0] THRESH_OFS = 8'h08;
	localparam logic [7:0] GUARD_OFS  = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;

	// Control fields
	localparam int LIMITER_ENABLE_BIT   = 0;
	localparam int GUARD_EN_BIT = 1;

	// Timing fields
	localparam int ATK_INT_LSB  = 0;
	localparam int HOLD_LSB     = 4;
	localparam int REL_INT_LSB  = 8;
	localparam int ATK_STEP_LSB = 12;
	localparam int REL_STEP_LSB = 14;
	localparam int CEIL_LSB     = 16;

	// Threshold fields
	localparam int UPPER_LSB = 0;
	localparam int KNEE_LSB  = 8;
	localparam int LOWER_LSB = 16;
	localparam int SLOPE_LSB = 24;

	// Status fields
	localparam int ST_ATN_LSB   = 0;
	localparam int ST_LIM_BIT   = 8;
	localparam int ST_GUARD_BIT = 9;
	localparam int ST_THR_LSB   = 16;

	// Reset values
	localparam logic       LIMITER_ENABLE_RST   = 1'b0;
	localparam logic       GUARD_EN_RST = 1'b1;
	localparam logic [2:0] ATK_INT_RST  = 3'h2;
	localparam logic [2:0] HOLD_RST     = 3'h6;
	localparam logic [2:0] REL_INT_RST  = 3'h6;
	localparam logic [1:0] ATK_STEP_RST = 2'h1;
	localparam logic [1:0] REL_STEP_RST = 2'h1;
	localparam logic [4:0] CEIL_RST     = 5'h10;
	localparam logic [6:0] UPPER_RST    = 7'h6e;
	localparam logic [6:0] KNEE_RST     = 7'h58;
	localparam logic [6:0] LOWER_RST    = 7'h1e;
	localparam logic [1:0] SLOPE_RST    = 2'h0;
	localparam logic [7:0] GUARD_TH_RST = 8'h14;

	// Code tables for times
	localparam int ATTACK_US  [8] = '{5, 10, 20, 40, 80, 160, 320, 640};
	localparam int HOLD_MS    [8] = '{0, 10, 25, 50, 100, 250, 500, 1000};
	localparam int RELEASE_MS [8] = '{10, 50, 100, 250, 500, 750, 1000, 1500};

	// Attenuation in quarter dB
	localparam int STEP_Q   [4] = '{1, 2, 4, 8};
	localparam int ATN_BASE = 4;
	localparam int ATN_PER  = 2;

	// Voltages in 25 mV units
	localparam int THR_BASE   = 80;
	localparam int THR_PER    = 4;
	localparam int GUARD_BASE = 180;
	localparam int SLOPE_X2 [4] = '{2, 3, 4, 8};

	localparam int TIMER_W = 21;
	localparam int ATN_W   = 7;
	localparam int VOLT_W  = 10;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_ATTACK,
		PH_HOLD,
		PH_RELEASE
	} blt_phase_t;

	typedef struct packed {
		logic       limiter_enable;
		logic       guard_enable;
		logic [2:0] attack_interval;
		logic [2:0] hold_duration;
		logic [2:0] release_interval;
		logic [1:0] attack_step_db;
		logic [1:0] release_step_db;
		logic [4:0] attenuation_ceiling;
		logic [6:0] upper_threshold;
		logic [6:0] tracking_knee;
		logic [6:0] lower_threshold;
		logic [1:0] tracking_slope;
		logic [7:0] brownout_guard_threshold;
	} blt_cfg_t;

endpackage

// >>> rtl/blt_timer.sv
`timescale 1ns/1ps

// Microsecond down counter; expired while it rests at zero
module blt_timer
	import blt_pkg::*;
#(
	parameter int WIDTH = TIMER_W
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             tick,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_val,
	output logic                  expired
);

	logic [WIDTH-1:0] count;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
		end else if (load) begin
			count <= load_val;
		end else if (tick && count != '0) begin
			count <= count - WIDTH'(1);
		end
	end

	// Sequencers feed load from expired; gating by load here would close a comb loop
	assign expired = (count == '0);

endmodule
